// >>> rtl/regulator_regs_pkg.sv
// Package for the regulator status and control register group.
// Assumes byte-wide page-0 offsets and one system clock.
package regulator_regs_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] VOLT_BASE_OFFSET            = 8'h60;
    localparam logic [7:0] VOLT_LAST_OFFSET            = 8'h6C;
    localparam logic [7:0] POWER_GOOD_OFFSET           = 8'h71;
    localparam logic [7:0] ALWAYS_ON_OFFSET            = 8'h72;
    localparam logic [7:0] FAULT_IRQ_ENABLE_OFFSET     = 8'h73;
    localparam logic [7:0] FAULT_STATUS_OFFSET         = 8'h75;
    localparam logic [7:0] WRITE_PROTECT_OFFSET        = 8'h77;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int         EXT_REG_COUNT               = 7;
    localparam int         SMALL_REG0_INDEX            = 3;
    localparam int         ENABLE_BIT                  = 7;
    localparam int         FIRST_PROTECTED_BIT         = 4;
    localparam int         PROTECT_WIDTH               = 3;
    localparam int         POWER_GOOD_WIDTH            = 3;
    localparam int         FAULT_WIDTH                 = 4;
    localparam logic [7:0] SMALL_REG0_RESET            = 8'h2A;
    localparam logic [7:0] OTHER_REG_RESET             = 8'h12;
    localparam logic [7:0] READ_ZERO                   = 8'h00;

    // ----------------------------------------------------------------
    // shared decode and arithmetic
    // ----------------------------------------------------------------
    function automatic logic is_volt_addr(input logic [7:0] addr);
        is_volt_addr = (addr >= VOLT_BASE_OFFSET) && (addr <= VOLT_LAST_OFFSET) && !addr[0];
    endfunction : is_volt_addr

    function automatic logic [2:0] volt_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff       = addr - VOLT_BASE_OFFSET;
        volt_index = diff[3:1];
    endfunction : volt_index

    function automatic logic [7:0] volt_reset(input int idx);
        volt_reset = (idx == SMALL_REG0_INDEX) ? SMALL_REG0_RESET : OTHER_REG_RESET;
    endfunction : volt_reset

    // protected bits keep their old value, the rest take the write
    function automatic logic [7:0] merge_protected(input logic [7:0] old_val,
                                                   input logic [7:0] new_val,
                                                   input logic [2:0] protect);
        logic [7:0] keep;
        keep            = {1'b0, protect, 4'h0};
        merge_protected = (old_val & keep) | (new_val & ~keep);
    endfunction : merge_protected

endpackage : regulator_regs_pkg

// >>> rtl/volt_reg_bank.sv
// Output-voltage registers of the seven external regulators.
// Assumes the decode and write-protect mask come from the register group.
`timescale 1ns/1ns
module volt_reg_bank
    import regulator_regs_pkg::*;
#(
    parameter int COUNT = EXT_REG_COUNT
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 wr_en,
    input  wire logic [2:0]           wr_idx,
    input  wire logic [7:0]           wr_data,
    input  wire logic [2:0]           protect,
    input  wire logic                 rd_en,
    input  wire logic [2:0]           rd_idx,
    output logic      [7:0]           rd_data,
    output logic      [COUNT*8-1:0]   contents
);

    typedef struct packed {
        logic [COUNT-1:0][7:0] regs;
        logic [7:0]            rdata;
    } bank_state_t;

    bank_state_t state;
    bank_state_t next_state;

    always_comb begin
        next_state = state;
        if (wr_en && (int'(wr_idx) < COUNT)) begin
            next_state.regs[wr_idx] = merge_protected(state.regs[wr_idx], wr_data, protect);
            // enable bit of small regulator 0 is reserved and stays clear
            if (int'(wr_idx) == SMALL_REG0_INDEX) begin
                next_state.regs[wr_idx][ENABLE_BIT] = 1'b0;
            end
        end
        if (rd_en) begin
            next_state.rdata = (int'(rd_idx) < COUNT) ? state.regs[rd_idx] : READ_ZERO;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < COUNT; i++) begin
                state.regs[i] <= volt_reset(i);
            end
            state.rdata <= READ_ZERO;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data  = state.rdata;
    assign contents = state.regs;

endmodule : volt_reg_bank

// >>> rtl/regulator_status_control_regs.sv
// Regulator status and control register group, byte wide, page 0.
// Assumes the bus bridge (serial slave or controller port) presents one
// access per cycle on reg_addr with reg_wr or reg_rd.
`timescale 1ns/1ns
// Summary of operation
// - status byte bits 0..2 show audio high, clockgen low, clockgen high power good
// - power good bits 7..3 read zero; writes to that byte do nothing
// - always-on byte bit 0 picks 3.0 V when set, resets to 3.3 V
// - fault irq enable byte for seven external regulators, all reset disabled
// - enable bits 0..2 large regulators, 3..6 small regulators, bit 7 reserved
// - fault status byte bits 0..3 flag audio, clockgen low/high, always-on faults
// - protect byte bits 0..2 block writes to voltage bits 4..6
// - protected voltage bits writable while protect bit is clear; bits 7..3 reserved
// - voltage registers hold 7-bit code, 25 mV steps over 750 mV, bit 7 enable (reserved and kept clear for small regulator 0)
module regulator_status_control_regs
    import regulator_regs_pkg::*;
#(
    parameter int REG_COUNT = EXT_REG_COUNT
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic [7:0]                reg_addr,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [7:0]                reg_wdata,
    output logic      [7:0]                reg_rdata,
    output logic                           reg_rvalid,
    input  wire logic [POWER_GOOD_WIDTH-1:0] rail_good_in,
    input  wire logic [FAULT_WIDTH-1:0]    rail_fault_in,
    output logic                           always_on_volt_select,
    output logic      [REG_COUNT-1:0]      external_fault_irq_enable,
    output logic      [PROTECT_WIDTH-1:0]  write_protect,
    output logic      [REG_COUNT*8-1:0]    regulator_settings
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [POWER_GOOD_WIDTH-1:0] rail_good;
        logic [FAULT_WIDTH-1:0]      rail_fault;
        logic                        ao_select;
        logic [REG_COUNT-1:0]        irq_enable;
        logic [PROTECT_WIDTH-1:0]    protect;
        logic                        rd_pending;
        logic                        rd_from_bank;
        logic [7:0]                  rd_local;
        logic [7:0]                  rdata;
        logic                        rvalid;
    } regs_state_t;

    regs_state_t state;
    regs_state_t next_state;

    logic [7:0]  bank_rdata;
    logic        bank_wr;
    logic        bank_rd;

    // a read of a voltage register takes the bank's registered word, so
    // every read is given the same two-cycle latency
    assign bank_wr = reg_wr && is_volt_addr(reg_addr);
    assign bank_rd = reg_rd && is_volt_addr(reg_addr);

    volt_reg_bank #(
        .COUNT    (REG_COUNT)
    ) u_bank (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .wr_en    (bank_wr),
        .wr_idx   (volt_index(reg_addr)),
        .wr_data  (reg_wdata),
        .protect  (state.protect),
        .rd_en    (bank_rd),
        .rd_idx   (volt_index(reg_addr)),
        .rd_data  (bank_rdata),
        .contents (regulator_settings)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_state            = state;
        // status inputs are sampled every cycle, reads see the sampled copy
        next_state.rail_good  = rail_good_in;
        next_state.rail_fault = rail_fault_in;
        next_state.rvalid     = 1'b0;

        // writes: read-only and reserved offsets fall through and are dropped
        if (reg_wr) begin
            case (reg_addr)
                ALWAYS_ON_OFFSET: begin
                    next_state.ao_select = reg_wdata[0];
                end
                FAULT_IRQ_ENABLE_OFFSET: begin
                    next_state.irq_enable = reg_wdata[REG_COUNT-1:0];
                end
                WRITE_PROTECT_OFFSET: begin
                    next_state.protect = reg_wdata[PROTECT_WIDTH-1:0];
                end
                default: begin
                    next_state.protect = state.protect;
                end
            endcase
        end

        // read stage one: pick local byte, remember whether bank answers
        next_state.rd_pending   = reg_rd;
        next_state.rd_from_bank = bank_rd;
        if (reg_rd) begin
            case (reg_addr)
                POWER_GOOD_OFFSET: begin
                    next_state.rd_local = {5'h00, state.rail_good};
                end
                ALWAYS_ON_OFFSET: begin
                    next_state.rd_local = {7'h00, state.ao_select};
                end
                FAULT_IRQ_ENABLE_OFFSET: begin
                    next_state.rd_local = {1'b0, state.irq_enable};
                end
                FAULT_STATUS_OFFSET: begin
                    next_state.rd_local = {4'h0, state.rail_fault};
                end
                WRITE_PROTECT_OFFSET: begin
                    next_state.rd_local = {5'h00, state.protect};
                end
                default: begin
                    next_state.rd_local = READ_ZERO;
                end
            endcase
        end

        // read stage two: present the byte for one cycle
        if (state.rd_pending) begin
            next_state.rdata  = state.rd_from_bank ? bank_rdata : state.rd_local;
            next_state.rvalid = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata                 = state.rdata;
    assign reg_rvalid                = state.rvalid;
    assign always_on_volt_select     = state.ao_select;
    assign external_fault_irq_enable = state.irq_enable;
    assign write_protect             = state.protect;

endmodule : regulator_status_control_regs

// >>> testbench/regulator_host_model.sv
// Host model: single-byte register accesses on the strobe bus.
// Assumes the register group answers a read two edges after it is taken.
`timescale 1ns/1ns
module regulator_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h76 || a[7:3] == 5'h0F) return;
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        // released lines show the inverse, never a stale copy
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        d = 8'hXX;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        repeat (3) begin
            @(negedge ref_clk);
            if (reg_rvalid) begin
                d = reg_rdata;
                break;
            end
        end
    endtask : read_reg
endmodule : regulator_host_model

// >>> testbench/regulator_regs_assertions.sv
// Checker for the regulator register group, bound to its top module.
// Assumes single-cycle strobes and a two-edge read answer.
`timescale 1ns/1ns
module regulator_regs_checker
    import regulator_regs_pkg::*;
#(
    parameter int REG_COUNT = EXT_REG_COUNT
) (
    input wire logic                        ref_clk,
    input wire logic                        reset,
    input wire logic [7:0]                  reg_addr,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [7:0]                  reg_wdata,
    input wire logic [7:0]                  reg_rdata,
    input wire logic                        reg_rvalid,
    input wire logic [POWER_GOOD_WIDTH-1:0] rail_good_in,
    input wire logic [FAULT_WIDTH-1:0]      rail_fault_in,
    input wire logic                        always_on_volt_select,
    input wire logic [REG_COUNT-1:0]        external_fault_irq_enable,
    input wire logic [PROTECT_WIDTH-1:0]    write_protect,
    input wire logic [REG_COUNT*8-1:0]      regulator_settings
);
    logic [7:0] slot0;
    logic [7:0] keep;
    logic [REG_COUNT*9+PROTECT_WIDTH:0] state_all;
    assign slot0     = regulator_settings[7:0];
    assign keep      = {1'b0, write_protect, 4'h0};
    assign state_all = {always_on_volt_select, external_fault_irq_enable, write_protect,
                        regulator_settings};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_power_good_read: assert property (
        reg_rd && reg_addr == 8'h71 && $stable(rail_good_in)
        |-> ##2 reg_rvalid && reg_rdata == {5'h00, $past(rail_good_in, 2)})
        else $error("power good read wrong");
    a_fault_read: assert property (
        reg_rd && reg_addr == 8'h75 && $stable(rail_fault_in)
        |-> ##2 reg_rvalid && reg_rdata == {4'h0, $past(rail_fault_in, 2)})
        else $error("fault status read wrong");
    a_status_write_ignored: assert property (
        reg_wr && reg_addr == 8'h71 |=> $stable(state_all))
        else $error("status write changed state");
    a_always_on_write: assert property (
        reg_wr && reg_addr == 8'h72 |=> {7'h00, always_on_volt_select} == ($past(reg_wdata) & 8'h01))
        else $error("always-on select not written");
    a_irq_enable_write: assert property (
        reg_wr && reg_addr == 8'h73
        |=> {1'b0, external_fault_irq_enable} == ($past(reg_wdata) & 8'h7F))
        else $error("irq enable not written");
    a_protect_write: assert property (
        reg_wr && reg_addr == 8'h77 |=> {5'h00, write_protect} == ($past(reg_wdata) & 8'h07))
        else $error("protect byte not written");
    a_protected_bits_kept: assert property (
        reg_wr && reg_addr == 8'h60 |=> (slot0 & 8'h70) ==
        ((($past(slot0) & $past(keep)) | ($past(reg_wdata) & ~$past(keep))) & 8'h70))
        else $error("protected voltage bits wrong");
    a_open_bits_written: assert property (
        reg_wr && reg_addr == 8'h60 |=> (slot0 & 8'h8F) == ($past(reg_wdata) & 8'h8F))
        else $error("voltage code bits not written");
endmodule : regulator_regs_checker

bind regulator_status_control_regs regulator_regs_checker #(.REG_COUNT(REG_COUNT)) chk (
    .ref_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .rail_good_in, .rail_fault_in, .always_on_volt_select, .external_fault_irq_enable,
    .write_protect, .regulator_settings);

// >>> testbench/regulator_status_control_regs_test.sv
// Testbench for the regulator register group: register tests via the host model.
// Assumes a 50 MHz clock and the two-edge read answer.
`timescale 1ns/1ns
module regulator_status_control_regs_test;
    import regulator_regs_pkg::*;
    logic                  ref_clk;
    logic                  reset;
    logic [7:0]            reg_addr, reg_wdata, reg_rdata, d;
    logic                  reg_wr, reg_rd, reg_rvalid, always_on_volt_select;
    logic [2:0]            rail_good_in, write_protect;
    logic [3:0]            rail_fault_in;
    logic [6:0]            external_fault_irq_enable;
    logic [55:0]           regulator_settings;
    int                    fail_count, num_checks, cycles;

    regulator_status_control_regs uut (.ref_clk, .reset, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid, .rail_good_in, .rail_fault_in,
        .always_on_volt_select, .external_fault_irq_enable, .write_protect, .regulator_settings);
    regulator_host_model host (.ref_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, d);
        check(name, d, exp);
    endtask : rd_chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // a hang is cut short well past the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        reset         = 1'b1;
        rail_good_in  = 3'h0;
        rail_fault_in = 4'h0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk("always_on", 8'h72, 8'h00);
        rd_chk("irq_enable", 8'h73, 8'h00);
        rd_chk("protect", 8'h77, 8'h00);
        rd_chk("fault", 8'h75, 8'h00);
        rd_chk("volt_small0", 8'h66, 8'h2A);
        rd_chk("volt_large0", 8'h60, 8'h12);
        $display("test reset_values done");
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            rail_good_in  <= i[2:0];
            rail_fault_in <= i[3:0];
            host.write_reg(8'h71, 8'hFF);
            rd_chk("power_good", 8'h71, {5'h00, i[2:0]});
            rd_chk("fault", 8'h75, {4'h0, i[3:0]});
        end
        $display("test status done");
        host.write_reg(8'h72, 8'hFF);
        rd_chk("always_on", 8'h72, 8'h01);
        check("always_on_port", {7'h00, always_on_volt_select}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            host.write_reg(8'h73, 8'h01 << i);
            rd_chk("irq_enable", 8'h73, (8'h01 << i) & 8'h7F);
            check("irq_port", {1'b0, external_fault_irq_enable}, (8'h01 << i) & 8'h7F);
        end
        $display("test controls done");
        host.write_reg(8'h77, 8'hFF);
        rd_chk("protect", 8'h77, 8'h07);
        host.write_reg(8'h60, 8'hFF);
        rd_chk("volt_locked", 8'h60, 8'h9F);
        host.write_reg(8'h77, 8'h00);
        host.write_reg(8'h60, 8'h70);
        rd_chk("volt_open", 8'h60, 8'h70);
        host.write_reg(8'h77, 8'h02);
        host.write_reg(8'h60, 8'h00);
        rd_chk("volt_bit5", 8'h60, 8'h20);
        check("volt_port", regulator_settings[7:0], 8'h20);
        $display("test protect done");
        host.write_reg(8'h78, 8'h55);
        rd_chk("reserved", 8'h78, 8'h00);
        rd_chk("unmapped", 8'h74, 8'h00);
        host.write_reg(8'h61, 8'hFF);
        rd_chk("volt_odd", 8'h60, 8'h20);
        host.write_reg(8'h77, 8'h00);
        host.write_reg(8'h66, 8'hFF);
        rd_chk("volt_small0_en", 8'h66, 8'h7F);
        $display("test unmapped done");
        // a second reset in mid-run must bring back the always-on, protect and both written voltage registers
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk("always_on_rst", 8'h72, 8'h00);
        rd_chk("protect_rst", 8'h77, 8'h00);
        rd_chk("volt_small0_rst", 8'h66, 8'h2A);
        rd_chk("volt_large0_rst", 8'h60, 8'h12);
        $display("test mid_reset done");
        summarize();
    end
endmodule : regulator_status_control_regs_test
